/* bbe_exec.sv */
// Executor for relative jump, bit set and bit test-and-skip instructions
`timescale 1ns/1ps
`default_nettype none
module bbe_exec
    import bbe_pkg::*;
(
    input  wire logic               REF_CLK_I,
    input  wire logic               SYS_RST_I,
    input  wire logic [15:0]        INSTR_WORD_I,
    input  wire logic               INSTR_VALID_I,
    input  wire logic               NEXT_TWO_WORD_I,
    input  wire logic [PC_W-1:0]    PC_I,
    output logic      [PC_W-1:0]    PC_TARGET_O,
    output logic                    PC_LOAD_O,
    output logic                    FLUSH_O,
    output logic                    NOP_O,
    output logic      [ADDR_W-1:0]  FREG_ADDR_O,
    input  wire logic [7:0]         FREG_RDATA_I,
    output logic      [7:0]         FREG_WDATA_O,
    output logic                    FREG_WE_O,
    input  wire logic [RADDR_W-1:0] REG_ADDR_I,
    input  wire logic [7:0]         REG_WDATA_I,
    input  wire logic               REG_WR_I,
    input  wire logic               REG_RD_I,
    output logic      [RDATA_W-1:0] REG_RDATA_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoder
    bbe_dec_if dec ();

    bbe_decoder u_dec (
        .d (dec.dec_mp)
    );

    logic [1:0]         q_reg,     q_next;
    bbe_state_t         state_reg, state_next;
    logic [15:0]        ir_reg,    ir_next;
    logic               irv_reg,   irv_next;
    logic [ADDR_W-1:0]  addr_reg,  addr_next;
    logic               we_reg,    we_next;
    logic [7:0]         wdata_reg, wdata_next;
    logic               pcl_reg,   pcl_next;
    logic [PC_W-1:0]    pct_reg,   pct_next;
    logic               flush_reg, flush_next;
    logic               two_reg,   two_next;
    logic               nop_reg,   nop_next;
    logic [BANK_W-1:0]  bsel_reg,  bsel_next;
    logic [RDATA_W-1:0] rdata_reg, rdata_next;
    logic [2:0]         last_reg,  last_next;
    logic               skip;

    assign dec.word  = ir_reg;
    assign dec.valid = irv_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction sequencing across the Q1..Q4 phases
    always_comb begin
        q_next     = q_reg + 2'h1;
        state_next = state_reg;
        ir_next    = ir_reg;
        irv_next   = irv_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        pct_next   = pct_reg;
        two_next   = two_reg;
        last_next  = last_reg;
        we_next    = 1'b0;
        pcl_next   = 1'b0;
        flush_next = 1'b0;
        skip       = 1'b0;
        unique case (q_reg)
            // Instructions are only taken in an executing cycle
            Q_FETCH: begin
                ir_next  = INSTR_WORD_I;
                irv_next = INSTR_VALID_I && (state_reg == ST_EXEC);
            end
            Q_READ: begin
                addr_next = bank_addr(dec.acc, dec.faddr, bsel_reg);
            end
            // Data from the register file is sampled in Q3 and acted on in Q4
            Q_PROC: begin
                two_next = 1'b0;
                unique case (dec.op)
                    OP_JUMP: begin
                        pcl_next   = 1'b1;
                        pct_next   = PC_I + jump_disp(dec.offset);
                        flush_next = 1'b1;
                    end
                    OP_BSET: begin
                        we_next    = 1'b1;
                        wdata_next = FREG_RDATA_I | bit_mask(dec.bit_idx);
                    end
                    OP_TSC: skip = !FREG_RDATA_I[dec.bit_idx];
                    OP_TSS: skip = FREG_RDATA_I[dec.bit_idx];
                    default: skip = 1'b0;
                endcase
                if (skip) begin
                    flush_next = 1'b1;
                    two_next   = NEXT_TWO_WORD_I;
                end
                if (irv_reg) begin
                    last_next = {two_next, skip, dec.op == OP_JUMP};
                end
            end
            Q_WRITE: begin
                unique case (state_reg)
                    ST_EXEC: begin
                        // A flush costs one no-op cycle, two when it hides a two-word op
                        if (flush_reg) begin
                            state_next = two_reg ? ST_NOP_FIRST : ST_NOP_LAST;
                        end
                    end
                    ST_NOP_FIRST: state_next = ST_NOP_LAST;
                    ST_NOP_LAST:  state_next = ST_EXEC;
                    default:      state_next = ST_EXEC;
                endcase
            end
            default: q_next = Q_FETCH;
        endcase
        nop_next = (state_next != ST_EXEC);
    end

    // Sequencing state; the flush and write strobes stand for Q4 only
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            q_reg     <= Q_FETCH;
            state_reg <= ST_EXEC;
            ir_reg    <= 16'h0000;
            irv_reg   <= 1'b0;
            addr_reg  <= '0;
            we_reg    <= 1'b0;
            wdata_reg <= 8'h00;
            pcl_reg   <= 1'b0;
            pct_reg   <= '0;
            flush_reg <= 1'b0;
            two_reg   <= 1'b0;
            nop_reg   <= 1'b0;
            last_reg  <= 3'h0;
        end else begin
            q_reg     <= q_next;
            state_reg <= state_next;
            ir_reg    <= ir_next;
            irv_reg   <= irv_next;
            addr_reg  <= addr_next;
            we_reg    <= we_next;
            wdata_reg <= wdata_next;
            pcl_reg   <= pcl_next;
            pct_reg   <= pct_next;
            flush_reg <= flush_next;
            two_reg   <= two_next;
            nop_reg   <= nop_next;
            last_reg  <= last_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port; a bank change lands at once, mid-instruction included
    always_comb begin
        bsel_next  = bsel_reg;
        rdata_next = '0;
        if (REG_WR_I && (REG_ADDR_I == REG_BANK_SEL)) begin
            bsel_next = REG_WDATA_I[BANK_W-1:0];
        end
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                REG_BANK_SEL: rdata_next = {{(RDATA_W-BANK_W){1'b0}}, bsel_reg};
                REG_STATUS:   rdata_next = {4'h0, last_reg, nop_reg};
                default:      rdata_next = '0;   // Unmapped reads as zero
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            bsel_reg  <= BANK_SEL_RST;
            rdata_reg <= '0;
        end else begin
            bsel_reg  <= bsel_next;
            rdata_reg <= rdata_next;
        end
    end

    assign PC_TARGET_O  = pct_reg;
    assign PC_LOAD_O    = pcl_reg;
    assign FLUSH_O      = flush_reg;
    assign NOP_O        = nop_reg;
    assign FREG_ADDR_O  = addr_reg;
    assign FREG_WDATA_O = wdata_reg;
    assign FREG_WE_O    = we_reg;
    assign REG_RDATA_O  = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_jump_nop_cycle: assert property (PC_LOAD_O |=> NOP_O [*4] ##1 !NOP_O)
        else $error("jump not followed by exactly one no-op cycle");

    a_jump_target_sum: assert property (
        PC_LOAD_O |-> PC_TARGET_O == $past(PC_I) + jump_disp(ir_reg[OFS_W-1:0]))
        else $error("jump target is not incremented PC plus twice offset");

    a_jump_pattern: assert property (
        PC_LOAD_O |-> ir_reg[15:JUMP_OPC_LSB] == OPC_JUMP && FLUSH_O)
        else $error("jump loaded PC without the jump pattern");

    a_bset_value: assert property (
        FREG_WE_O |-> FREG_WDATA_O == ($past(FREG_RDATA_I) | bit_mask(ir_reg[BIT_LSB+2:BIT_LSB])))
        else $error("bit set wrote a wrong value");

    a_bset_single_cycle: assert property (
        FREG_WE_O |-> ir_reg[15:OP4_LSB] == OPC_BSET && !FLUSH_O ##1 !NOP_O [*4])
        else $error("bit set did not complete in one cycle");

    a_access_bank: assert property (
        q_reg == Q_PROC && dec.op != OP_NONE && dec.op != OP_JUMP && !dec.acc
        |-> FREG_ADDR_O == {(dec.faddr[SPLIT_POS] ? ACCESS_HI_BANK : ACCESS_LO_BANK), dec.faddr})
        else $error("access bank not used when access bit is 0");

    a_bank_select: assert property (
        q_reg == Q_PROC && dec.op != OP_NONE && dec.op != OP_JUMP && dec.acc
        |-> FREG_ADDR_O == {$past(bsel_reg), dec.faddr})
        else $error("bank select not used when access bit is 1");

    a_clear_skip: assert property (
        q_reg == Q_PROC && dec.op == OP_TSC |-> ##1 FLUSH_O == !$past(FREG_RDATA_I[dec.bit_idx]))
        else $error("skip-if-clear decision wrong");

    a_set_noskip: assert property (
        q_reg == Q_PROC && dec.op == OP_TSS && !FREG_RDATA_I[dec.bit_idx]
        |=> !FLUSH_O ##1 !NOP_O)
        else $error("skip-if-set disturbed the next instruction");

    a_set_skip: assert property (
        q_reg == Q_PROC && dec.op == OP_TSS && FREG_RDATA_I[dec.bit_idx] |=> FLUSH_O)
        else $error("skip-if-set did not skip");

    a_two_word_skip: assert property (
        FLUSH_O && two_reg |=> NOP_O [*8] ##1 !NOP_O)
        else $error("two-word skip did not take two no-op cycles");

    c_jump:     cover property (PC_LOAD_O);
    c_bset:     cover property (FREG_WE_O);
    c_skip_one: cover property (FLUSH_O && !two_reg && !PC_LOAD_O);
    c_skip_two: cover property (FLUSH_O && two_reg);

endmodule
`default_nettype wire

/* bbe_pkg.sv */
// Shared constants, types and helpers for the branch, bit-set and bit-test executor
package bbe_pkg;

    // Widths
    localparam int BANK_W  = 4;
    localparam int FADDR_W = 8;
    localparam int ADDR_W  = BANK_W + FADDR_W;
    localparam int PC_W    = 21;
    localparam int OFS_W   = 11;
    localparam int RADDR_W = 2;
    localparam int RDATA_W = 8;

    // Opcode patterns
    localparam logic [4:0] OPC_JUMP = 5'h1a;
    localparam logic [3:0] OPC_BSET = 4'h8;
    localparam logic [3:0] OPC_TSC  = 4'hb;
    localparam logic [3:0] OPC_TSS  = 4'ha;

    // Field positions inside the instruction word
    localparam int JUMP_OPC_LSB = 11;
    localparam int OP4_LSB      = 12;
    localparam int BIT_LSB      = 9;
    localparam int ACC_POS      = 8;
    localparam int SPLIT_POS    = 7;

    // Access bank halves
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;

    // Register port map and reset values
    localparam logic [RADDR_W-1:0] REG_BANK_SEL = 2'h0;
    localparam logic [RADDR_W-1:0] REG_STATUS   = 2'h1;
    localparam logic [BANK_W-1:0]  BANK_SEL_RST = 4'h0;

    // Phases of the four-clock instruction cycle
    localparam logic [1:0] Q_FETCH = 2'h0;
    localparam logic [1:0] Q_READ  = 2'h1;
    localparam logic [1:0] Q_PROC  = 2'h2;
    localparam logic [1:0] Q_WRITE = 2'h3;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_JUMP = 3'h1,
        OP_BSET = 3'h2,
        OP_TSC  = 3'h3,
        OP_TSS  = 3'h4
    } bbe_op_t;

    // Gray along the usual exec -> last nop -> exec path; a two-word skip
    // detours through first nop, since no three-state loop can stay Gray
    typedef enum logic [1:0] {
        ST_EXEC      = 2'h0,
        ST_NOP_LAST  = 2'h1,
        ST_NOP_FIRST = 2'h3
    } bbe_state_t;

    // Full file address from the access bit, the short address and the bank select
    function automatic logic [ADDR_W-1:0] bank_addr(input logic acc,
                                                    input logic [FADDR_W-1:0] f,
                                                    input logic [BANK_W-1:0] bsel);
        if (acc) begin
            bank_addr = {bsel, f};
        end else begin
            bank_addr = {(f[SPLIT_POS] ? ACCESS_HI_BANK : ACCESS_LO_BANK), f};
        end
    endfunction

    // Signed word offset turned into a byte displacement
    function automatic logic [PC_W-1:0] jump_disp(input logic [OFS_W-1:0] ofs);
        jump_disp = {{(PC_W-OFS_W-1){ofs[OFS_W-1]}}, ofs, 1'b0};
    endfunction

    // One-hot mask of the selected bit
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

endpackage

/* bbe_dec_if.sv */
// Carrier between the executor and its instruction decoder
`timescale 1ns/1ps
`default_nettype none
interface bbe_dec_if;
    import bbe_pkg::*;
    logic [15:0]        word;
    logic               valid;
    bbe_op_t            op;
    logic [2:0]         bit_idx;
    logic               acc;
    logic [FADDR_W-1:0] faddr;
    logic [OFS_W-1:0]   offset;

    modport dec_mp (input word, input valid,
                    output op, output bit_idx, output acc, output faddr, output offset);
    modport use_mp (output word, output valid,
                    input op, input bit_idx, input acc, input faddr, input offset);
endinterface
`default_nettype wire

/* bbe_decoder.sv */
// Instruction word decoder for the four supported instructions
`timescale 1ns/1ps
`default_nettype none
module bbe_decoder
    import bbe_pkg::*;
(
    bbe_dec_if.dec_mp d
);
    // Operand fields sit at fixed places in every word
    assign d.bit_idx = d.word[BIT_LSB+2:BIT_LSB];
    assign d.acc     = d.word[ACC_POS];
    assign d.faddr   = d.word[FADDR_W-1:0];
    assign d.offset  = d.word[OFS_W-1:0];

    // Opcode match; the five-bit jump pattern is checked first
    always_comb begin
        d.op = OP_NONE;
        if (!d.valid) begin
            d.op = OP_NONE;
        end else if (d.word[15:JUMP_OPC_LSB] == OPC_JUMP) begin
            d.op = OP_JUMP;
        end else begin
            unique case (d.word[15:OP4_LSB])
                OPC_BSET: d.op = OP_BSET;
                OPC_TSC:  d.op = OP_TSC;
                OPC_TSS:  d.op = OP_TSS;
                default:  d.op = OP_NONE;       // Other instructions are not ours
            endcase
        end
    end
endmodule
`default_nettype wire

/* bbe_testbench.sv */
// Self-checking testbench for the branch, bit-set and bit-test executor
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bbe_pkg::*;
;
    logic              clk;
    logic              rst;
    logic [15:0]       word;
    logic              valid;
    logic              two_w;
    logic [PC_W-1:0]   pc;
    logic [PC_W-1:0]   tgt;
    logic              load;
    logic              flush;
    logic              no_operation;
    logic [ADDR_W-1:0] faddr;
    logic [7:0]        rdata;
    logic [7:0]        wdata;
    logic              we;
    logic [1:0]        raddr;
    logic [7:0]        rwdata;
    logic              wr;
    logic              rd;
    logic [7:0]        rrdata;
    logic [3:0]        bsel;
    int                errors;
    int                checked;
    int                e;

    bbe_exec u_dut (
        .REF_CLK_I       (clk),
        .SYS_RST_I       (rst),
        .INSTR_WORD_I    (word),
        .INSTR_VALID_I   (valid),
        .NEXT_TWO_WORD_I (two_w),
        .PC_I            (pc),
        .PC_TARGET_O     (tgt),
        .PC_LOAD_O       (load),
        .FLUSH_O         (flush),
        .NOP_O           (no_operation),
        .FREG_ADDR_O     (faddr),
        .FREG_RDATA_I    (rdata),
        .FREG_WDATA_O    (wdata),
        .FREG_WE_O       (we),
        .REG_ADDR_I      (raddr),
        .REG_WDATA_I     (rwdata),
        .REG_WR_I        (wr),
        .REG_RD_I        (rd),
        .REG_RDATA_O     (rrdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // 10 MHz core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare one value, four-state, so an unknown never matches
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Drivers act by non-blocking assignment at the edge, checks 1 ns later
    task automatic tick;
        @(posedge clk);
        e++;
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        tick;
        valid <= 1'b0;
        wr <= 1'b1;
        raddr <= a;
        rwdata <= d;
        tick;
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a, input logic [7:0] x);
        tick;
        valid <= 1'b0;
        rd <= 1'b1;
        raddr <= a;
        tick;
        rd <= 1'b0;
        #1;
        chk("reg_rdata", rrdata, x);
        tick;
        #1;
        chk("reg_idle", rrdata, 0);
    endtask

    // Expected file address; ex = {addr valid, write, flush, load}
    function automatic logic [ADDR_W-1:0] xaddr(input logic a, input logic [7:0] f);
        if (a) begin
            return {bsel, f};
        end
        return {(f[7] ? 4'hf : 4'h0), f};
    endfunction

    // One instruction cycle, then n no-op clocks with a decoy offered meanwhile
    task automatic instr(input logic [15:0] w, input logic v, input logic [7:0] rdv,
                         input logic tw, input logic [PC_W-1:0] p, input logic [3:0] ex,
                         input logic [7:0] xw, input logic [PC_W-1:0] xt,
                         input logic [ADDR_W-1:0] xa, input int n);
        while (e % 4 != 2) begin
            tick;
            valid <= 1'b0;
            #1;
        end
        tick;
        word <= w;
        valid <= v;
        rdata <= rdv;
        two_w <= tw;
        pc <= p;
        #1;
        chk("nop_tail", no_operation, 0);
        tick;
        valid <= 1'b0;
        tick;
        #1;
        chk("nop_end", no_operation, 0);
        if (ex[3]) chk("faddr", faddr, xa);
        tick;
        #1;
        chk("load", load, ex[0]);
        chk("flush", flush, ex[1]);
        chk("we", we, ex[2]);
        if (ex[2]) chk("wdata", wdata, xw);
        if (ex[0]) chk("target", tgt, xt);
        tick;
        word <= 16'h8fff;
        if (n > 0) valid <= 1'b1;
        #1;
        chk("pulses", {load, flush, we}, 0);
        chk("nop", no_operation, n > 0);
        // Run to the last no-op clock, so a decoy that slipped in shows its write
        for (int i = 0; i < n - 1; i++) begin
            tick;
            #1;
            chk("nop_hold", {no_operation, we}, 2'b10);
        end
    endtask

    task automatic bset(input logic [2:0] b, input logic a, input logic [7:0] f,
                        input logic [7:0] r);
        instr({4'h8, b, a, f}, 1'b1, r, 1'b0, 0, 4'b1100, r | (8'h01 << b), 0, xaddr(a, f), 0);
    endtask

    task automatic test(input logic [3:0] op, input logic [2:0] b, input logic a,
                        input logic [7:0] r, input logic tw);
        logic sk;
        sk = (r[b] == (op == OPC_TSS));
        instr({op, b, a, 8'h3c}, 1'b1, r, tw, 0, {2'b10, sk, 1'b0}, 0, 0, xaddr(a, 8'h3c),
              sk ? (tw ? 8 : 4) : 0);
    endtask

    task automatic jump(input logic [10:0] o, input logic [PC_W-1:0] p);
        int d;
        d = o[10] ? int'(o) - 2048 : int'(o);
        instr({5'h1a, o}, 1'b1, 0, 1'b0, p, 4'b0011, 0, p + PC_W'(2 * d), 0, 4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        word = 16'h0000;
        valid = 1'b0;
        two_w = 1'b0;
        pc = 0;
        rdata = 8'h00;
        raddr = 2'h0;
        rwdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        bsel = 4'h0;
        errors = 0;
        checked = 0;
        e = 0;
        repeat (11) tick;
        #1;
        chk("reset_out", {load, flush, no_operation, we, faddr, rrdata}, 0);
        tick;
        rst <= 1'b0;
        e = -1;
        #1;
        reg_rd(REG_BANK_SEL, 8'h00);
        reg_wr(REG_BANK_SEL, 8'hfa);
        reg_rd(REG_BANK_SEL, 8'h0a);
        bsel = 4'ha;
        reg_wr(2'h2, 8'h55);
        reg_rd(2'h2, 8'h00);
        reg_rd(2'h3, 8'h00);
        // Every bit index; odd ones through the bank select, even ones the access bank
        for (int b = 0; b < 8; b++) bset(b[2:0], b[0], 8'h80 | b[7:0], 8'h0a);
        bset(3'h7, 1'b0, 8'h12, 8'h0a);
        bset(3'h3, 1'b1, 8'hff, 8'hff);
        reg_wr(REG_BANK_SEL, 8'h03);
        bsel = 4'h3;
        bset(3'h2, 1'b1, 8'h44, 8'h00);
        // Both tests, bit clear and set, next word single and double
        for (int k = 0; k < 8; k++) begin
            test(k[2] ? OPC_TSS : OPC_TSC, k[2:0], k[0],
                 k[0] ? (8'h01 << k) : ~(8'h01 << k), k[1]);
        end
        reg_rd(REG_STATUS, 8'h0c);
        jump(11'h3ff, 21'h001000);
        jump(11'h400, 21'h000010);
        jump(11'h7ff, 21'h1ffffe);
        jump(11'h000, 21'h0abcde);
        reg_rd(REG_STATUS, 8'h02);
        // Near misses, an all-zero word and an invalid word must do nothing
        instr(16'hd800, 1'b1, 0, 1'b0, 0, 4'b0000, 0, 0, 0, 0);
        instr(16'h9fff, 1'b1, 0, 1'b0, 0, 4'b0000, 0, 0, 0, 0);
        instr(16'h8fff, 1'b0, 0, 1'b0, 0, 4'b0000, 0, 0, 0, 0);
        instr(16'h0000, 1'b1, 0, 1'b0, 0, 4'b0000, 0, 0, 0, 0);
        stop_test;
    end

    // Hang guard
    initial begin
        #1000000;
        errors++;
        stop_test;
    end
endmodule
`default_nettype wire
